/* verilog/booth_mult_pkg.sv */
// Shared constants and carrier types for the serial/parallel Booth multiplier
package booth_mult_pkg;

  // Default multiplicand width and number of cells
  localparam int unsigned MULT_WIDTH     = 8;

  // Values after reset or clear
  localparam logic        SUM_RST_VAL    = 1'h0;
  localparam logic        CARRY_RST_VAL  = 1'h0;
  localparam logic        PREV_RST_VAL   = 1'h0;
  localparam logic        PRODUCT_RST_VAL = 1'h0;
  localparam logic [1:0]  OP_RST_VAL     = 2'h0;

  // Width and reset value of the cycles-since-clear counter
  localparam int unsigned CYCLE_CNT_W    = 6;
  localparam logic [CYCLE_CNT_W-1:0] CYCLE_CNT_RST = 6'h00;

  // Bit positions of the recoded operation code
  localparam int unsigned OP_ADD_POS     = 0;
  localparam int unsigned OP_SUB_POS     = 1;

  // Current and previous serial multiplier bits, seen together by every cell
  typedef struct packed {
    logic y_cur;
    logic y_prev;
  } booth_pair_t;

  // Cascade inputs of the most significant cell
  typedef struct packed {
    logic mode;
    logic expansion;
  } cascade_t;

endpackage : booth_mult_pkg

/* verilog/booth_cell.sv */
// One stored-carry adder/subtractor cell of the Booth multiplier
`timescale 1ns/1ps
`default_nettype none

module booth_cell
  import booth_mult_pkg::*;
(
  // Operands
  input  wire logic        mcand_bit,
  input  wire booth_pair_t pair,
  // Running state of this stage
  input  wire logic        sum_in,
  input  wire logic        carry_in,
  // Results
  output logic             sum_out,
  output logic             carry_out
);

  logic gated;

  // Multiplicand or zero, chosen by the bit pair
  assign gated     = mcand_bit & (pair.y_prev ^ pair.y_cur);
  // Three-input sum of partial product, gated operand and stored carry
  assign sum_out   = sum_in ^ carry_in ^ gated;
  // Carry or borrow; borrow is a carry of weight -2 when y_cur is high
  assign carry_out = (sum_in ^ pair.y_cur) & (carry_in ^ gated);

endmodule : booth_cell

`default_nettype wire

/* verilog/booth_serial_parallel_multiplier.sv */
// Eight-stage serial/parallel two's complement Booth multiplier
//
// Summary of operation
// - Examine current and previous multiplier bits together
// - 00/11 shift only, 01 add, 10 subtract
// - Pair 11 cancels earlier subtract, extends sign
// - Each bit weighted negative, corrected next period
// - Carries stored in same stage, never rippled
// - New sum shifts into next lower stage
// - Every stage has its own carry flip-flop
// - Adder sums partial product, gated operand, carry
// - Bit pair picks add/subtract and operand/zero
// - Cell: five inputs, sum and carry outputs
// - Zero multiplicand bit passes sum, no carry
// - Borrows kept as negative carries, same flops
// - Additions and subtractions always alternate
// - Sum and carry equations per cell
// - Product leaves serially, least significant first
// - Eight identical cells; cascade feeds only the top sum flop
`timescale 1ns/1ps
`default_nettype none

module booth_serial_parallel_multiplier
  import booth_mult_pkg::*;
#(
  parameter int unsigned WIDTH = MULT_WIDTH
) (
  // Clock, reset and enable
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Control from the sequencer
  input  wire logic             clear_input_n,
  // Parallel multiplicand, held for a whole multiplication
  input  wire logic [WIDTH-1:0] multiplicand,
  // Serial multiplier, least significant bit first
  input  wire logic             mult_bit,
  // Cascade inputs of the top cell
  input  wire cascade_t         cascade,
  // Serial product, least significant bit first
  output logic                  product_bit,
  // Recoded operation of the period just completed, registered
  output logic [1:0]            booth_op,
  // Periods counted since the last clear, saturating
  output logic [CYCLE_CNT_W-1:0] cycle_count
);

  logic [WIDTH-1:0]       sum_ff;
  logic [WIDTH-1:0]       carry_ff;
  logic [WIDTH-1:0]       cell_sum;
  logic [WIDTH-1:0]       cell_carry;
  logic [WIDTH-1:0]       nxt_sum;
  logic                   prev_ff;
  logic                   product_ff;
  logic [1:0]             op_ff;
  logic [CYCLE_CNT_W-1:0] cycle_ff;
  booth_pair_t            pair;
  logic                   clearing;
  logic                   mcand_stable_ff;

  assign clearing = ~clear_input_n;

  // Same pair fans out to every cell
  assign pair.y_cur  = mult_bit;
  assign pair.y_prev = prev_ff;

  // Remembers the bit of the previous period for recoding
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_ff <= PREV_RST_VAL;
    end else if (clk_en) begin
      if (clearing) begin
        prev_ff <= PREV_RST_VAL;
      end else begin
        prev_ff <= mult_bit;
      end
    end
  end

  // Identical cells; only the feed of the top sum flop differs
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_cell
      booth_cell u_cell (
        .mcand_bit (multiplicand[gi]),
        .pair      (pair),
        .sum_in    (sum_ff[gi]),
        .carry_in  (carry_ff[gi]),
        .sum_out   (cell_sum[gi]),
        .carry_out (cell_carry[gi])
      );
      if (gi < WIDTH - 1) begin : g_low
        assign nxt_sum[gi] = cell_sum[gi+1];
      end else begin : g_top
        // Cascaded: take the upper device's output; alone: sign extend
        assign nxt_sum[gi] = cascade.mode ? cascade.expansion : cell_sum[gi];
      end
    end
  endgenerate

  // Partial product shifts one place down every period
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sum_ff <= {WIDTH{SUM_RST_VAL}};
    end else if (clk_en) begin
      if (clearing) begin
        sum_ff <= {WIDTH{SUM_RST_VAL}};
      end else begin
        sum_ff <= nxt_sum;
      end
    end
  end

  // Carries stay put, so the per-period delay does not grow with width
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      carry_ff <= {WIDTH{CARRY_RST_VAL}};
    end else if (clk_en) begin
      if (clearing) begin
        carry_ff <= {WIDTH{CARRY_RST_VAL}};
      end else begin
        carry_ff <= cell_carry;
      end
    end
  end

  // Bottom cell's sum is the next product bit, registered for the output
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      product_ff <= PRODUCT_RST_VAL;
    end else if (clk_en) begin
      if (clearing) begin
        product_ff <= PRODUCT_RST_VAL;
      end else begin
        product_ff <= cell_sum[0];
      end
    end
  end

  assign product_bit = product_ff;

  // Operation actually applied, for the sequencer and for debug
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op_ff <= OP_RST_VAL;
    end else if (clk_en) begin
      if (clearing) begin
        op_ff <= OP_RST_VAL;
      end else begin
        op_ff[OP_ADD_POS] <= ~mult_bit & prev_ff;
        op_ff[OP_SUB_POS] <= mult_bit & ~prev_ff;
      end
    end
  end

  assign booth_op = op_ff;

  // Saturates so a long truncated run cannot wrap to a small figure
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cycle_ff <= CYCLE_CNT_RST;
    end else if (clk_en) begin
      if (clearing) begin
        cycle_ff <= CYCLE_CNT_RST;
      end else if (cycle_ff != {CYCLE_CNT_W{1'b1}}) begin
        cycle_ff <= cycle_ff + {{(CYCLE_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign cycle_count = cycle_ff;

  // Watches whether the multiplicand stayed fixed since the last clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mcand_stable_ff <= 1'b0;
    end else if (clk_en) begin
      if (clearing) begin
        mcand_stable_ff <= 1'b1;
      end else if (multiplicand != $past(multiplicand)) begin
        mcand_stable_ff <= 1'b0;
      end
    end
  end

  property p_prev_bit;
    @(posedge sys_clk) disable iff (sys_rst)
      (!$past(sys_rst) && $past(clk_en) && $past(clear_input_n)) |-> (prev_ff == $past(mult_bit));
  endproperty
  a_prev_bit: assert property (p_prev_bit) else $error("previous bit not kept");

  property p_clear;
    @(posedge sys_clk) disable iff (sys_rst)
      ($past(clk_en) && !$past(clear_input_n)) |->
        (sum_ff == '0 && carry_ff == '0 && !prev_ff && !product_ff);
  endproperty
  a_clear: assert property (p_clear) else $error("clear left state set");

  property p_shift;
    @(posedge sys_clk) disable iff (sys_rst)
      (!$past(sys_rst) && $past(clk_en) && $past(clear_input_n)) |->
        (sum_ff[WIDTH-2:0] == $past(cell_sum[WIDTH-1:1]));
  endproperty
  a_shift: assert property (p_shift) else $error("partial product did not shift down");

  property p_carry_stays;
    @(posedge sys_clk) disable iff (sys_rst)
      (!$past(sys_rst) && $past(clk_en) && $past(clear_input_n)) |-> (carry_ff == $past(cell_carry));
  endproperty
  a_carry_stays: assert property (p_carry_stays) else $error("carry moved between stages");

  property p_freeze;
    @(posedge sys_clk) disable iff (sys_rst)
      (!$past(sys_rst) && !$past(clk_en)) |->
        ($stable(sum_ff) && $stable(carry_ff) && $stable(prev_ff) && $stable(cycle_ff));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state changed while disabled");

  property p_nop_pass;
    @(posedge sys_clk) disable iff (sys_rst)
      (mult_bit == prev_ff) |-> (cell_sum == (sum_ff ^ carry_ff));
  endproperty
  a_nop_pass: assert property (p_nop_pass) else $error("equal pair changed the sum");

  property p_add_sum;
    @(posedge sys_clk) disable iff (sys_rst)
      (!mult_bit && prev_ff) |-> (cell_sum == (sum_ff ^ carry_ff ^ multiplicand));
  endproperty
  a_add_sum: assert property (p_add_sum) else $error("add pair did not add multiplicand");

  property p_zero_bit;
    @(posedge sys_clk) disable iff (sys_rst)
      (mcand_stable_ff && $stable(multiplicand)) |-> ((carry_ff & ~multiplicand) == '0);
  endproperty
  a_zero_bit: assert property (p_zero_bit) else $error("zero multiplicand bit set its carry");

  property p_zero_pass;
    @(posedge sys_clk) disable iff (sys_rst)
      (mcand_stable_ff && $stable(multiplicand)) |-> ((cell_sum & ~multiplicand) == (sum_ff & ~multiplicand));
  endproperty
  a_zero_pass: assert property (p_zero_pass) else $error("zero multiplicand bit altered sum");

  property p_alternate;
    @(posedge sys_clk) disable iff (sys_rst)
      ($past(clk_en) && $past(clear_input_n) && clk_en && clear_input_n) |->
        !(op_ff[OP_ADD_POS] && (~mult_bit & prev_ff)) && !(op_ff[OP_SUB_POS] && (mult_bit & ~prev_ff));
  endproperty
  a_alternate: assert property (p_alternate) else $error("two like operations in a row");

  property p_product;
    @(posedge sys_clk) disable iff (sys_rst)
      (!$past(sys_rst) && $past(clk_en) && $past(clear_input_n)) |-> (product_bit == $past(cell_sum[0]));
  endproperty
  a_product: assert property (p_product) else $error("product bit not from bottom cell");

  property p_top_feed;
    @(posedge sys_clk) disable iff (sys_rst)
      (!$past(sys_rst) && $past(clk_en) && $past(clear_input_n)) |->
        (sum_ff[WIDTH-1] == ($past(cascade.mode) ? $past(cascade.expansion) : $past(cell_sum[WIDTH-1])));
  endproperty
  a_top_feed: assert property (p_top_feed) else $error("top stage fed wrongly");

  property p_count;
    @(posedge sys_clk) disable iff (sys_rst)
      ($past(clk_en) && !$past(clear_input_n) && clk_en && clear_input_n) |=>
        (cycle_count == 6'h01);
  endproperty
  a_count: assert property (p_count) else $error("cycle count not one after first period");

endmodule : booth_serial_parallel_multiplier

`default_nettype wire

/* dv/booth_seq_model.sv */
// Sequencer model: clears, streams the multiplier, gathers the product
`timescale 1ns/1ps
`default_nettype none

module booth_seq_model (
  // Clock and requests
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic [7:0]  mcand_in,
  input  wire logic [7:0]  mplier_in,
  // Multiplier side
  output logic             clear_input_n,
  output logic [7:0]       multiplicand,
  output logic             mult_bit,
  input  wire logic        product_bit,
  // Result
  output logic [15:0]      product,
  output logic             done
);
  logic [7:0] shift_ff;
  logic [4:0] step_ff;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      step_ff <= 5'h00;
      clear_input_n <= 1'h1;
      done <= 1'h0;
      multiplicand <= 8'h00;
      mult_bit <= 1'h0;
      product <= 16'h0000;
      shift_ff <= 8'h00;
    end else if (clk_en) begin
      if (step_ff == 5'h00 && start) begin
        multiplicand <= mcand_in;
        shift_ff <= mplier_in;
        clear_input_n <= 1'h0;
        done <= 1'h0;
        step_ff <= 5'h01;
      end else if (step_ff != 5'h00) begin
        clear_input_n <= 1'h1;
        mult_bit <= shift_ff[0];
        // Sign bit repeated once the word is used up
        shift_ff <= {shift_ff[7], shift_ff[7:1]};
        // Product bit lags its multiplier bit by one edge
        if (step_ff >= 5'h03) product <= {product_bit, product[15:1]};
        step_ff <= (step_ff == 5'h12) ? 5'h00 : step_ff + 5'h01;
        done <= (step_ff == 5'h12);
      end
    end
  end
endmodule : booth_seq_model

`default_nettype wire

/* dv/booth_serial_parallel_multiplier_tb.sv */
// Self-checking bench for the serial/parallel Booth multiplier
`timescale 1ns/1ps
`default_nettype none

module booth_serial_parallel_multiplier_tb
  import booth_mult_pkg::*;
;
  logic sys_clk = 1'h0;
  logic sys_rst, clk_en, start, clear_input_n, mult_bit, product_bit, done;
  logic [7:0] a_in, b_in, multiplicand;
  logic [15:0] product;
  logic [1:0] booth_op, exp_op;
  logic [CYCLE_CNT_W-1:0] cycle_count, exp_cnt;
  cascade_t cascade;
  logic cur_b, prev_b, clr_s, en_s, tracking, last_pb;
  int err_count, n_checks;
  logic [7:0] av [8] = '{8'h00, 8'h7F, 8'h80, 8'h80, 8'h05, 8'hFF, 8'h55, 8'h01};
  logic [7:0] bv [8] = '{8'h00, 8'h7F, 8'h80, 8'h7F, 8'hFD, 8'hFF, 8'hAA, 8'h80};

  always #25 sys_clk = ~sys_clk;

  booth_serial_parallel_multiplier DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .clear_input_n(clear_input_n), .multiplicand(multiplicand), .mult_bit(mult_bit), .cascade(cascade),
    .product_bit(product_bit), .booth_op(booth_op), .cycle_count(cycle_count));

  booth_seq_model seq (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .start(start),
    .mcand_in(a_in), .mplier_in(b_in), .clear_input_n(clear_input_n), .multiplicand(multiplicand),
    .mult_bit(mult_bit), .product_bit(product_bit), .product(product), .done(done));

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // One clock with a running model of the recoded op and the count
  task tick;
    @(negedge sys_clk);
    cur_b = mult_bit;
    clr_s = clear_input_n;
    en_s = clk_en;
    @(posedge sys_clk);
    #2;
    if (en_s && !clr_s) begin
      tracking = 1'h1;
      prev_b = 1'h0;
      exp_op = 2'h0;
      exp_cnt = '0;
    end else if (en_s && tracking) begin
      exp_op = {cur_b & ~prev_b, ~cur_b & prev_b};
      prev_b = cur_b;
      if (exp_cnt != 6'h3F) exp_cnt = exp_cnt + 6'h01;
    end
    if (tracking) begin
      chk("booth_op", {14'h0, exp_op}, {14'h0, booth_op});
      chk("cycle_count", {10'h0, exp_cnt}, {10'h0, cycle_count});
      if (!en_s) chk("frozen product_bit", {15'h0, last_pb}, {15'h0, product_bit});
    end
    last_pb = product_bit;
  endtask : tick

  // Gap names the enabled step at which clk_en drops for one cycle
  task multiply(input logic [7:0] a, input logic [7:0] b, input int gap);
    logic signed [15:0] exp_p;
    int n;
    exp_p = $signed(a) * $signed(b);
    a_in = a;
    b_in = b;
    start = 1'h1;
    tick;
    start = 1'h0;
    n = 0;
    while (done !== 1'h1 && n < 40) begin
      clk_en = (n != gap);
      tick;
      n++;
    end
    clk_en = 1'h1;
    if (n >= 40) begin
      err_count++;
      $display("[FAIL] done expected 1 seen %b", done);
      conclude;
    end
    chk("product", exp_p, product);
  endtask : multiply

  task saturate;
    repeat (70) tick;
    chk("saturated count", 16'h003F, {10'h0, cycle_count});
  endtask : saturate

  task reset_midrun;
    a_in = 8'h7F;
    b_in = 8'h81;
    start = 1'h1;
    tick;
    start = 1'h0;
    repeat (5) tick;
    sys_rst = 1'h1;
    tracking = 1'h0;
    @(posedge sys_clk);
    #2;
    chk("outputs in reset", 16'h0000, {7'h0, product_bit, booth_op, cycle_count});
    sys_rst = 1'h0;
  endtask : reset_midrun

  // Zero multiplicand: the only way a one reaches the output is the top input
  task cascade_chain;
    int n;
    cascade = '{mode: 1'h1, expansion: 1'h1};
    n = 0;
    while (product_bit !== 1'h1 && n < 12) begin
      tick;
      n++;
    end
    chk("expansion at product", 16'h0001, {15'h0, product_bit});
    chk("expansion latency", 16'h0009, n[15:0]);
    cascade = '0;
  endtask : cascade_chain

  initial begin
    sys_rst = 1'h1;
    clk_en = 1'h1;
    start = 1'h0;
    a_in = 8'h00;
    b_in = 8'h00;
    cascade = '0;
    err_count = 0;
    n_checks = 0;
    tracking = 1'h0;
    prev_b = 1'h0;
    exp_op = 2'h0;
    exp_cnt = '0;
    last_pb = 1'h0;
    repeat (16) @(posedge sys_clk);
    #2;
    sys_rst = 1'h0;
    chk("outputs after reset", 16'h0000, {7'h0, product_bit, booth_op, cycle_count});
    for (int i = 0; i < 8; i++) multiply(av[i], bv[i], (i == 3) ? 5 : 99);
    saturate;
    reset_midrun;
    multiply(8'h00, 8'h5A, 99);
    cascade_chain;
    multiply(8'hC3, 8'h3C, 99);
    conclude;
  end
endmodule : booth_serial_parallel_multiplier_tb

`default_nettype wire
